//--- core/fspp_ctrl.v
// flash controller: sector protect register, erase enable and byte programming
// assumes register file bus and program store requests synchronous to mclk_i
// Summary of operation
// - protection bits can only be set by writes; writing zero leaves them set
// - control write other than select code deselects protect register, restores page select
// - reset clears all protection bits, every sector unprotected
// - a set protection bit refuses program and erase in its sector
// - byte programming only when unlocked and mass or page erase enabled
// - unlocked with mass erase enabled, any location in an unprotected sector may be programmed
// - unlocked with page erase enabled, only the selected page may be programmed
// - an erased byte reads as all ones
// - programming only clears bits; ones return only through erase
// - program requests come from debugger writes and cpu store instructions
// - cpu is stalled during programming while clocks keep running
// - control write other than erase commands ends programming and relocks
`timescale 1ns/1ps
`include "fspp_defs.vh"
module fspp_ctrl (
	input wire mclk_i,
	input wire rst_i,
	input wire [11:0] rf_addr_i,
	input wire [7:0] rf_wdata_i,
	input wire rf_wr_i,
	input wire rf_rd_i,
	output reg [7:0] rf_rdata_o,
	input wire cpu_store_i,
	input wire [10:0] cpu_addr_i,
	input wire [7:0] cpu_data_i,
	input wire dbg_write_i,
	input wire [10:0] dbg_addr_i,
	input wire [7:0] dbg_data_i,
	input wire [10:0] fetch_addr_i,
	output reg [7:0] fetch_data_o,
	output reg cpu_stall_o,
	output reg prog_refused_o
);
	localparam [3:0] ST_LOCKED = 4'h1;
	localparam [3:0] ST_MASS = 4'h2;
	localparam [3:0] ST_PAGE = 4'h4;
	localparam [3:0] ST_BUSY = 4'h8;
	localparam [3:0] PROG_CYC = `FSPP_PROG_CYC;

	reg [7:0] mem [0:`FSPP_MEM_WORDS-1];
	reg [3:0] state_reg;
	reg [3:0] ret_state_reg;
	reg [1:0] unlock_reg;
	reg prot_sel_reg;
	reg [7:0] sector_write_protect_reg;
	reg [7:0] page_sel_reg;
	reg [3:0] cnt_reg;
	reg [10:0] pa_reg;
	reg [7:0] pd_reg;
	reg erase_all_reg;
	reg erase_page_reg;
	reg [11:0] erase_ptr_reg;

	wire ctrl_wr = rf_wr_i && (rf_addr_i == `FSPP_CTRL_ADDR);
	wire shared_wr = rf_wr_i && (rf_addr_i == `FSPP_PROT_ADDR);
	wire req = cpu_store_i | dbg_write_i;
	wire [10:0] req_addr = dbg_write_i ? dbg_addr_i : cpu_addr_i;
	wire [7:0] req_data = dbg_write_i ? dbg_data_i : cpu_data_i;
	wire [2:0] req_sector = req_addr[10:`FSPP_SECTOR_LSB];
	wire req_prot = sector_write_protect_reg[req_sector];
	wire in_page = (req_addr[10:`FSPP_PAGE_LSB] == page_sel_reg[1:0]);
	wire prog_ok = req && !req_prot && !erase_all_reg && !erase_page_reg &&
		((state_reg == ST_MASS) || ((state_reg == ST_PAGE) && in_page));
	wire unlocked = (unlock_reg == 2'h2);
	wire [2:0] page_sector = {page_sel_reg[1:0], 1'b0};
	wire page_prot = sector_write_protect_reg[page_sector] |
		sector_write_protect_reg[page_sector + 3'h1];

	// erase sweep; mass erase skips protected sectors, page erase sweep does not check protection
	wire [10:0] ep = erase_ptr_reg[10:0];
	wire ep_free = !sector_write_protect_reg[ep[10:`FSPP_SECTOR_LSB]];
	always @(posedge mclk_i) begin
		if (erase_all_reg && ep_free)
			mem[ep] <= `FSPP_ERASED_BYTE;
		else if (erase_page_reg)
			mem[{page_sel_reg[1:0], ep[8:0]}] <= `FSPP_ERASED_BYTE;
		else if ((state_reg == ST_BUSY) && (cnt_reg == 4'h1))
			mem[pa_reg] <= mem[pa_reg] & pd_reg;
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_LOCKED;
			ret_state_reg <= ST_LOCKED;
			unlock_reg <= 2'h0;
			prot_sel_reg <= 1'b0;
			sector_write_protect_reg <= `FSPP_PROT_RESET;
			page_sel_reg <= 8'h00;
			cnt_reg <= 4'h0;
			pa_reg <= 11'h000;
			pd_reg <= 8'hFF;
			erase_all_reg <= 1'b0;
			erase_page_reg <= 1'b0;
			erase_ptr_reg <= 12'h000;
			cpu_stall_o <= 1'b0;
			prog_refused_o <= 1'b0;
			rf_rdata_o <= 8'h00;
			fetch_data_o <= 8'hFF;
		end else begin
			prog_refused_o <= req && !prog_ok && (state_reg != ST_BUSY);
			fetch_data_o <= mem[fetch_addr_i];
			if (erase_all_reg || erase_page_reg) begin
				erase_ptr_reg <= erase_ptr_reg + 12'h001;
				if ((erase_all_reg && erase_ptr_reg == 12'h7FF) ||
						(erase_page_reg && erase_ptr_reg == 12'h1FF)) begin
					erase_all_reg <= 1'b0;
					erase_page_reg <= 1'b0;
				end
			end
			if (shared_wr) begin
				if (prot_sel_reg)
					sector_write_protect_reg <= sector_write_protect_reg | rf_wdata_i;
				else
					page_sel_reg <= rf_wdata_i;
			end
			if (rf_rd_i) begin
				case (rf_addr_i)
				`FSPP_PROT_ADDR: rf_rdata_o <= prot_sel_reg ? sector_write_protect_reg :
					page_sel_reg;
				`FSPP_STAT_ADDR: rf_rdata_o <= {4'h0, state_reg};
				default: rf_rdata_o <= 8'h00;
				endcase
			end
			if (ctrl_wr) begin
				prot_sel_reg <= (rf_wdata_i == `FSPP_CMD_PROT_SEL);
				if (rf_wdata_i == `FSPP_CMD_UNLOCK1) begin
					unlock_reg <= 2'h1;
					state_reg <= ST_LOCKED;
					cpu_stall_o <= 1'b0;
				end else if (rf_wdata_i == `FSPP_CMD_UNLOCK2 && unlock_reg == 2'h1) begin
					unlock_reg <= 2'h2;
					state_reg <= ST_LOCKED;
					cpu_stall_o <= 1'b0;
				end else if (rf_wdata_i == `FSPP_CMD_MASS_ERASE && unlocked) begin
					if (sector_write_protect_reg != 8'hFF) begin
						state_reg <= ST_MASS;
						erase_all_reg <= 1'b1;
						erase_ptr_reg <= 12'h000;
					end
				end else if (rf_wdata_i == `FSPP_CMD_PAGE_ERASE && unlocked) begin
					if (!page_prot) begin
						state_reg <= ST_PAGE;
						erase_page_reg <= 1'b1;
						erase_ptr_reg <= 12'h000;
					end
				end else begin
					unlock_reg <= 2'h0;
					state_reg <= ST_LOCKED;
					cpu_stall_o <= 1'b0;
				end
			end else begin
				case (state_reg)
				ST_LOCKED: cpu_stall_o <= 1'b0;
				ST_MASS, ST_PAGE: begin
					if (prog_ok) begin
						ret_state_reg <= state_reg;
						state_reg <= ST_BUSY;
						pa_reg <= req_addr;
						pd_reg <= req_data;
						cnt_reg <= PROG_CYC;
						cpu_stall_o <= 1'b1;
					end
				end
				ST_BUSY: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= ret_state_reg;
						cpu_stall_o <= 1'b0;
					end
				end
				default: state_reg <= ST_LOCKED;
				endcase
			end
		end
	end
endmodule // fspp_ctrl

//--- core/fspp_defs.vh
// flash sector protect and byte program constants
// assumes an 8-bit register file bus and a 2 kbyte flash array
`ifndef FSPP_DEFS_VH
`define FSPP_DEFS_VH
`define FSPP_CTRL_ADDR 12'hFF8
`define FSPP_PROT_ADDR 12'hFF9
`define FSPP_STAT_ADDR 12'hFFA
`define FSPP_CMD_RESET 8'h00
`define FSPP_CMD_PROT_SEL 8'h5E
`define FSPP_CMD_UNLOCK1 8'h73
`define FSPP_CMD_UNLOCK2 8'h8C
`define FSPP_CMD_MASS_ERASE 8'h63
`define FSPP_CMD_PAGE_ERASE 8'h95
`define FSPP_PROT_RESET 8'h00
`define FSPP_ERASED_BYTE 8'hFF
`define FSPP_MEM_AW 11
`define FSPP_MEM_WORDS 2048
`define FSPP_PAGE_LSB 9
`define FSPP_SECTOR_LSB 8
`define FSPP_PROG_TIME_NS 40
`define FSPP_PROG_CYC 4'h5
`define FSPP_ERASE_CYC 8
`define FSPP_ST_LOCKED 0
`define FSPP_ST_MASS 1
`define FSPP_ST_PAGE 2
`define FSPP_ST_BUSY 3
`endif

//--- dv/fspp_ctrl_props.sv
// checker: flash controller port relations
// assumes a bind onto fspp_ctrl
`timescale 1ns/1ps
module fspp_ctrl_props(
	input wire mclk_i,
	input wire rst_i,
	input wire [11:0] rf_addr_i,
	input wire [7:0] rf_wdata_i,
	input wire rf_wr_i,
	input wire rf_rd_i,
	input wire [7:0] rf_rdata_o,
	input wire cpu_store_i,
	input wire dbg_write_i,
	input wire [7:0] fetch_data_o,
	input wire cpu_stall_o,
	input wire prog_refused_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire req = cpu_store_i | dbg_write_i;
	sequence stall5; cpu_stall_o [*5] ##1 !cpu_stall_o; endsequence
	sequence relock; rf_wr_i && rf_addr_i == 12'hFF8 && rf_wdata_i != 8'h63 && rf_wdata_i != 8'h95;
	endsequence
	stall_len_a: assert property ($rose(cpu_stall_o) |-> stall5) else $error("stall len");
	stall_cause_a: assert property ($rose(cpu_stall_o) |-> $past(req)) else $error("stall");
	req_answer_a: assert property (req && !cpu_stall_o |=> cpu_stall_o || prog_refused_o) else $error("req");
	refuse_nostall_a: assert property (prog_refused_o |-> !cpu_stall_o) else $error("refuse");
	refuse_cause_a: assert property (prog_refused_o |-> $past(req)) else $error("refuse");
	relock_a: assert property (relock ##[1:3] req |=> prog_refused_o) else $error("relock");
	reset_out_a: assert property ($fell(rst_i) |-> fetch_data_o == 8'hFF && !cpu_stall_o) else $error("rst");
	read_hold_a: assert property (!rf_rd_i |=> $stable(rf_rdata_o)) else $error("read");
endmodule // fspp_ctrl_props

//--- dv/fspp_host.sv
// host model: cpu store, debugger write and register bus
// assumes mclk_i shared with the controller
`timescale 1ns/1ps
module fspp_host(
	input wire mclk_i,
	output reg [11:0] a_o,
	output reg [7:0] d_o,
	output reg [3:0] k_o
);
	initial begin
		a_o = '0;
		d_o = '0;
		k_o = '0;
	end
	// k_o: dbg write, cpu store, read, write; one cycle each
	task op(input [3:0] k, input [11:0] a, input [7:0] d);
		begin
			@(posedge mclk_i);
			k_o <= k;
			a_o <= a;
			d_o <= d;
			@(posedge mclk_i);
			k_o <= '0;
			d_o <= ~d;
		end
	endtask
endmodule // fspp_host

//--- dv/fspp_ctrl_tb.sv
// testbench: protect, erase and program flows
// assumes fspp_ctrl, fspp_host, 125 MHz clock
`timescale 1ns/1ps
module flash_sector_protect_and_program_tb;
	reg mclk_i = 0;
	reg rst_i = 1;
	wire [11:0] a;
	wire [7:0] d, rdat, fd;
	wire [3:0] k;
	wire stl, rf;
	integer fail_count = 0, n_checks = 0, seed = 59641;
	reg [7:0] v;
	reg ps = 0;
	reg q[$];
	fspp_host h(.mclk_i(mclk_i), .a_o(a), .d_o(d), .k_o(k));
	fspp_ctrl dut(.mclk_i(mclk_i), .rst_i(rst_i), .rf_addr_i(a), .rf_wdata_i(d), .rf_wr_i(k[0]),
		.rf_rd_i(k[1]), .rf_rdata_o(rdat), .cpu_store_i(k[2]), .cpu_addr_i(a[10:0]),
		.cpu_data_i(d), .dbg_write_i(k[3]), .dbg_addr_i(a[10:0]), .dbg_data_i(d),
		.fetch_addr_i(a[10:0]), .fetch_data_o(fd), .cpu_stall_o(stl), .prog_refused_o(rf));
	initial forever #4 mclk_i = ~mclk_i;
	task chk(input [7:0] g, input [7:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
			else $display("DONE - FAIL");
			$finish;
		end
	endtask
	task rdc(input [11:0] ad, input [7:0] e);
		begin
			h.op(4'h2, ad, 8'h00);
			#1 chk(rdat, e);
		end
	endtask
	task prog(input [3:0] kk, input [10:0] ad, input [7:0] dd, input r, input [7:0] e);
		begin
			q.push_back(r);
			h.op(kk, {1'b0, ad}, dd);
			repeat (7) @(posedge mclk_i);
			#1 if (e !== 8'hxx) chk(fd, e);
			$display("program %h done", ad);
		end
	endtask
	// each stall start or refusal settles the oldest noted outcome
	always @(posedge mclk_i) begin
		ps <= stl;
		if ((stl === 1'b1 && !ps) || rf === 1'b1) begin
			if (q.size() == 0) chk(8'h01, 8'h00);
			else chk(rf, q.pop_front());
		end
	end
	initial begin
		#800000 fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 0;
		h.op(4'h1, 12'hFF8, 8'h00);
		h.op(4'h1, 12'hFF8, 8'h5E);
		rdc(12'hFF9, 8'h00);
		h.op(4'h1, 12'hFF9, 8'h01);
		h.op(4'h1, 12'hFF9, 8'h00);
		rdc(12'hFF9, 8'h01);
		h.op(4'h1, 12'hFF8, 8'h00);
		h.op(4'h1, 12'hFF8, 8'h73);
		h.op(4'h1, 12'hFF8, 8'h8C);
		h.op(4'h1, 12'hFF8, 8'h63);
		repeat (2060) @(posedge mclk_i);
		rdc(12'hFFA, 8'h02);
		prog(4'h4, 11'h010, 8'h00, 1, 8'hxx);
		v = $random(seed);
		prog(4'h4, 11'h100, v, 0, v);
		prog(4'h8, 11'h100, 8'h0F, 0, v & 8'h0F);
		h.op(4'h1, 12'hFF8, 8'h00);
		prog(4'h4, 11'h100, 8'h00, 1, v & 8'h0F);
		h.op(4'h1, 12'hFF8, 8'h73);
		h.op(4'h1, 12'hFF8, 8'h8C);
		h.op(4'h1, 12'hFF9, 8'h02);
		h.op(4'h1, 12'hFF8, 8'h95);
		repeat (520) @(posedge mclk_i);
		rdc(12'hFFA, 8'h04);
		prog(4'h8, 11'h4A5, v, 0, v);
		prog(4'h4, 11'h100, 8'h00, 1, v & 8'h0F);
		h.op(4'h1, 12'hFF8, 8'h73);
		prog(4'h8, 11'h4A6, 8'h00, 1, 8'hFF);
		stop_test;
	end
endmodule // flash_sector_protect_and_program_tb
bind fspp_ctrl fspp_ctrl_props u_props(.mclk_i, .rst_i, .rf_addr_i, .rf_wdata_i, .rf_wr_i,
	.rf_rd_i, .rf_rdata_o, .cpu_store_i, .dbg_write_i, .fetch_data_o, .cpu_stall_o, .prog_refused_o);
